// ---- bsdf_defs.svh ----
`ifndef BSDF_DEFS_SVH
`define BSDF_DEFS_SVH

// =====================================================
// Register byte offsets
`define BSDF_REG_CTRL      12'h000
`define BSDF_REG_RX_DELIM  12'h004
`define BSDF_REG_TX_DELIM  12'h008
`define BSDF_REG_TIMEOUT   12'h00c
`define BSDF_REG_STATUS    12'h010
`define BSDF_REG_RX_DATA   12'h014
`define BSDF_REG_COUNT     12'h018

// =====================================================
// Field positions in CTRL
`define BSDF_CTRL_RX_SLEN  1:0
`define BSDF_CTRL_RX_ELEN  3:2
`define BSDF_CTRL_TX_SLEN  5:4

// =====================================================
// Reset values
`define BSDF_CTRL_RST      6'h00
`define BSDF_DELIM_RST     32'h0000_0000
`define BSDF_TIMEOUT_RST   16'h000a

`endif

// ---- bsdf_pkg.sv ----
package bsdf_pkg;

  // Delimiter length encoding
  typedef enum logic [1:0] {
    BSDF_LEN_NONE = 2'h0,
    BSDF_LEN_ONE  = 2'h1,
    BSDF_LEN_TWO  = 2'h2
  } bsdf_len_t;

  // One byte beat on a stream
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       last;
  } bsdf_beat_t;

  // Receive states, one-hot
  typedef enum logic [3:0] {
    BSDF_RX_HUNT1 = 4'h1,
    BSDF_RX_HUNT2 = 4'h2,
    BSDF_RX_DATA  = 4'h4,
    BSDF_RX_END2  = 4'h8
  } bsdf_rx_state_t;

  // Transmit states, one-hot
  typedef enum logic [2:0] {
    BSDF_TX_IDLE = 3'h1,
    BSDF_TX_PRE1 = 3'h2,
    BSDF_TX_PRE2 = 3'h4
  } bsdf_tx_state_t;

endpackage

// ---- bsdf_framer.sv ----
`timescale 1ns/1ps
`include "bsdf_defs.svh"
// Operation
// - No start delimiter: first byte after previous end starts the next packet
// - One-byte start: hunt for start byte one, then collect data
// - While hunting, drop every byte not completing the start sequence
// - Two-byte start: collect only after start byte one then start byte two
// - Hold 8-bit first receive start character, used for lengths one and two
// - Hold second receive start character, matched for length two; also kept out of the drop count at length one
// - No end delimiter: close the packet when the inter-packet timeout expires
// - One-byte end: end byte one completes the packet
// - Two-byte end: end byte one followed by end byte two completes it
// - Hold first receive end character, used for lengths one and two
// - Hold second receive end character, used only for length two
// - Transmit prefix one byte emits start byte; none emits no prefix
// - Transmit prefix two bytes emits first then second start byte
// - Hold first transmit start character for prefix lengths one and two
// - Hold second transmit start character for prefix length two only
// - With end delimiter set, abandon waiting after the millisecond timeout
module bsdf_framer (
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Millisecond tick, same clock
  input  wire logic        ms_tick,
  // Bytes from the remote device
  input  bsdf_pkg::bsdf_beat_t rx_in,
  // Framed packet bytes to the controller
  output bsdf_pkg::bsdf_beat_t rx_out,
  output logic             rx_abort,
  // Packet bytes from the controller
  input  bsdf_pkg::bsdf_beat_t tx_in,
  output logic             tx_in_ready,
  // Bytes toward the remote device
  output bsdf_pkg::bsdf_beat_t tx_out,
  input  wire logic        tx_out_ready
);
  import bsdf_pkg::*;

  // =====================================================
  // Registers
  logic [5:0]  ctrl_q;
  logic [31:0] rx_delim_q;   // [7:0] start1 [15:8] start2 [23:16] end1 [31:24] end2
  logic [15:0] tx_delim_q;   // [7:0] start1 [15:8] start2
  logic [15:0] timeout_q;
  logic [15:0] pkt_cnt_q;
  logic [15:0] drop_cnt_q;
  logic [15:0] abort_cnt_q;

  wire bsdf_len_t rx_slen = bsdf_len_t'(ctrl_q[`BSDF_CTRL_RX_SLEN]);
  wire bsdf_len_t rx_elen = bsdf_len_t'(ctrl_q[`BSDF_CTRL_RX_ELEN]);
  wire bsdf_len_t tx_slen = bsdf_len_t'(ctrl_q[`BSDF_CTRL_TX_SLEN]);
  wire [7:0] rx_start1 = rx_delim_q[7:0];
  wire [7:0] rx_start2 = rx_delim_q[15:8];
  wire [7:0] rx_end1   = rx_delim_q[23:16];
  wire [7:0] rx_end2   = rx_delim_q[31:24];
  wire [7:0] tx_start1 = tx_delim_q[7:0];
  wire [7:0] tx_start2 = tx_delim_q[15:8];

  // =====================================================
  // APB decode; zero wait states, unmapped reads zero with error
  wire apb_acc  = psel & penable;
  wire apb_wr   = apb_acc & pwrite;
  wire hit_ctrl = (paddr == `BSDF_REG_CTRL);
  wire hit_rxd  = (paddr == `BSDF_REG_RX_DELIM);
  wire hit_txd  = (paddr == `BSDF_REG_TX_DELIM);
  wire hit_tmo  = (paddr == `BSDF_REG_TIMEOUT);
  wire hit_sts  = (paddr == `BSDF_REG_STATUS);
  wire hit_cnt  = (paddr == `BSDF_REG_RX_DATA) | (paddr == `BSDF_REG_COUNT);
  wire hit_any  = hit_ctrl | hit_rxd | hit_txd | hit_tmo | hit_sts | hit_cnt;

  assign pready  = 1'b1;
  assign pslverr = apb_acc & ~hit_any;

  // Configuration writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q     <= `BSDF_CTRL_RST;
      rx_delim_q <= `BSDF_DELIM_RST;
      tx_delim_q <= 16'h0000;
      timeout_q  <= `BSDF_TIMEOUT_RST;
    end else if (apb_wr) begin
      if (hit_ctrl) ctrl_q <= pwdata[5:0];
      if (hit_rxd) rx_delim_q <= pwdata;
      if (hit_txd) tx_delim_q <= pwdata[15:0];
      if (hit_tmo) timeout_q <= pwdata[15:0];
    end
  end

  // =====================================================
  // Receive framer
  bsdf_rx_state_t rx_state_q, rx_state_d;
  logic [15:0]    ms_cnt_q;
  logic           held_v_q;   // End1 seen, waiting to learn whether end2 follows
  bsdf_beat_t     rx_out_q;
  logic           abort_q;

  wire in_pkt    = (rx_state_q == BSDF_RX_DATA) | (rx_state_q == BSDF_RX_END2);
  wire b_vld     = rx_in.valid;
  wire [7:0] b   = rx_in.data;
  wire is_s1     = b_vld & (b == rx_start1);
  wire is_s2     = b_vld & (b == rx_start2);
  wire is_e1     = b_vld & (b == rx_end1);
  wire is_e2     = b_vld & (b == rx_end2);
  // Timer restarts on each byte, advanced only by the ms tick
  wire tmo_hit   = in_pkt & ~b_vld & ms_tick & (timeout_q != 16'h0000)
                 & (ms_cnt_q + 16'h0001 >= timeout_q);
  wire tmo_close = tmo_hit & (rx_elen == BSDF_LEN_NONE);
  wire tmo_abort = tmo_hit & (rx_elen != BSDF_LEN_NONE);
  wire hunt_home = (rx_slen == BSDF_LEN_NONE);
  // A new framing setup restarts the hunt, so stale state never frames new data
  wire ctrl_wr   = apb_wr & hit_ctrl;

  // State after a packet closes
  function automatic bsdf_rx_state_t rx_restart(input bsdf_len_t slen);
    rx_restart = (slen == BSDF_LEN_NONE) ? BSDF_RX_DATA : BSDF_RX_HUNT1;
  endfunction

  // Next state
  always_comb begin
    rx_state_d = rx_state_q;
    case (rx_state_q)
      BSDF_RX_HUNT1: begin
        if (hunt_home) rx_state_d = BSDF_RX_DATA;
        else if (is_s1)
          rx_state_d = (rx_slen == BSDF_LEN_TWO) ? BSDF_RX_HUNT2 : BSDF_RX_DATA;
      end
      BSDF_RX_HUNT2: begin
        if (is_s2) rx_state_d = BSDF_RX_DATA;
        else if (b_vld & ~is_s1) rx_state_d = BSDF_RX_HUNT1;
      end
      BSDF_RX_DATA: begin
        if (tmo_hit) rx_state_d = rx_restart(rx_slen);
        else if (is_e1 & (rx_elen == BSDF_LEN_ONE)) rx_state_d = rx_restart(rx_slen);
        else if (is_e1 & (rx_elen == BSDF_LEN_TWO)) rx_state_d = BSDF_RX_END2;
      end
      BSDF_RX_END2: begin
        if (tmo_hit) rx_state_d = rx_restart(rx_slen);
        else if (is_e2) rx_state_d = rx_restart(rx_slen);
        else if (b_vld & ~is_e1) rx_state_d = BSDF_RX_DATA;
      end
      default: rx_state_d = BSDF_RX_HUNT1;
    endcase
    if (ctrl_wr) rx_state_d = BSDF_RX_HUNT1;
  end

  // Delivered byte; end1 goes out at once, so no byte is ever held back
  wire end_now    = ((rx_state_q == BSDF_RX_DATA) & is_e1 & (rx_elen == BSDF_LEN_ONE))
                  | ((rx_state_q == BSDF_RX_END2) & is_e2);
  wire data_byte  = in_pkt & b_vld & ~tmo_hit & ~end_now;

  // Output stage; start bytes are consumed, end bytes stay, terminator marks last
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state_q <= BSDF_RX_HUNT1;
      ms_cnt_q   <= 16'h0000;
      held_v_q   <= 1'b0;
      rx_out_q   <= '0;
      abort_q    <= 1'b0;
    end else begin
      rx_state_q <= rx_state_d;
      abort_q    <= tmo_abort;
      // Restart after an expiry too, else every later tick would fire again
      if (b_vld | ~in_pkt | tmo_hit) ms_cnt_q <= 16'h0000;
      else if (ms_tick) ms_cnt_q <= ms_cnt_q + 16'h0001;
      rx_out_q.valid <= data_byte | end_now | tmo_close;
      rx_out_q.last  <= end_now | tmo_close;
      if (b_vld) rx_out_q.data <= b;
      else if (tmo_close) rx_out_q.data <= 8'h00;
      held_v_q <= (rx_state_d == BSDF_RX_END2);
    end
  end

  // =====================================================
  // Counters for status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pkt_cnt_q   <= 16'h0000;
      drop_cnt_q  <= 16'h0000;
      abort_cnt_q <= 16'h0000;
    end else begin
      if (end_now | tmo_close) pkt_cnt_q <= pkt_cnt_q + 16'h0001;
      if (b_vld & ~in_pkt & ~hunt_home & ~is_s1 & ~is_s2)
        drop_cnt_q <= drop_cnt_q + 16'h0001;
      if (tmo_abort) abort_cnt_q <= abort_cnt_q + 16'h0001;
    end
  end

  // =====================================================
  // Transmit prefix insertion
  bsdf_tx_state_t tx_state_q, tx_state_d;
  logic tx_busy_q;  // Inside a packet; cleared after the last byte
  wire sop_pending = tx_in.valid & ~tx_busy_q;

  always_comb begin
    tx_state_d = tx_state_q;
    case (tx_state_q)
      BSDF_TX_IDLE:
        if (sop_pending & (tx_slen != BSDF_LEN_NONE)) tx_state_d = BSDF_TX_PRE1;
      BSDF_TX_PRE1:
        if (tx_out_ready)
          tx_state_d = (tx_slen == BSDF_LEN_TWO) ? BSDF_TX_PRE2 : BSDF_TX_IDLE;
      BSDF_TX_PRE2:
        if (tx_out_ready) tx_state_d = BSDF_TX_IDLE;
      default: tx_state_d = BSDF_TX_IDLE;
    endcase
  end

  // Data passes only once the prefix is out; back-pressure goes straight through
  wire pfx_needed = sop_pending & (tx_slen != BSDF_LEN_NONE);
  wire pass_data  = (tx_state_q == BSDF_TX_IDLE) & ~pfx_needed;
  wire [7:0] pfx  = (tx_state_q == BSDF_TX_PRE2) ? tx_start2 : tx_start1;

  assign tx_in_ready   = pass_data & tx_out_ready;
  assign tx_out.valid  = (tx_state_q != BSDF_TX_IDLE) | (pass_data & tx_in.valid);
  assign tx_out.data   = (tx_state_q != BSDF_TX_IDLE) ? pfx : tx_in.data;
  assign tx_out.last   = (tx_state_q == BSDF_TX_IDLE) & tx_in.last;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state_q <= BSDF_TX_IDLE;
      tx_busy_q  <= 1'b0;
    end else begin
      tx_state_q <= tx_state_d;
      if (tx_state_q == BSDF_TX_PRE1 || tx_state_q == BSDF_TX_PRE2)
        tx_busy_q <= 1'b1;
      else if (tx_in.valid & tx_in_ready)
        tx_busy_q <= ~tx_in.last;
    end
  end

  // =====================================================
  // Read mux
  wire [31:0] sts_word = {12'h000, held_v_q, abort_q, tx_busy_q, in_pkt,
                          abort_cnt_q};
  assign prdata = !apb_acc ? 32'h0000_0000 :
                  hit_ctrl ? {26'h0, ctrl_q} :
                  hit_rxd  ? rx_delim_q :
                  hit_txd  ? {16'h0000, tx_delim_q} :
                  hit_tmo  ? {16'h0000, timeout_q} :
                  hit_sts  ? sts_word :
                  hit_cnt  ? {drop_cnt_q, pkt_cnt_q} : 32'h0000_0000;

  assign rx_out   = rx_out_q;
  assign rx_abort = abort_q;
endmodule

// ---- bsdf_framer_asserts.sv ----
`timescale 1ns/1ps
// =====================================================
// Framer stream checker
module bsdf_framer_asserts (
  // Clock and reset
  input wire logic            pclk,
  input wire logic            presetn,
  // Receive side
  input wire logic            ms_tick,
  input bsdf_pkg::bsdf_beat_t rx_in,
  input bsdf_pkg::bsdf_beat_t rx_out,
  input wire logic            rx_abort,
  // Transmit side
  input bsdf_pkg::bsdf_beat_t tx_in,
  input wire logic            tx_in_ready,
  input bsdf_pkg::bsdf_beat_t tx_out,
  input wire logic            tx_out_ready
);
  import bsdf_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Prefix byte offered while the packet byte waits
  sequence s_pre_hold;
    tx_in.valid && tx_out_ready && tx_out.valid && !tx_in_ready;
  endsequence
  sequence s_pre_two;
    s_pre_hold ##1 s_pre_hold;
  endsequence
  // Receive beats need a byte or a tick as cause
  a_rx_cause: assert property (rx_out.valid |-> $past(rx_in.valid) || $past(ms_tick))
    else $error("rx beat without cause");
  a_close_zero: assert property (rx_out.valid && !$past(rx_in.valid) |->
    rx_out.last && rx_out.data == 8'h00)
    else $error("timeout close beat wrong");
  a_abort_tick: assert property (rx_abort |-> $past(ms_tick))
    else $error("abort without tick");
  a_abort_pulse: assert property (rx_abort |=> !rx_abort)
    else $error("abort longer than one cycle");
  // Transmit: data passes only after the prefix
  a_tx_pass: assert property (tx_in_ready && tx_in.valid |->
    tx_out.valid && tx_out.data == tx_in.data)
    else $error("packet byte not passed");
  a_ready_gate: assert property (tx_in_ready |-> tx_out_ready)
    else $error("ready without sink ready");
  a_pre_bound: assert property (s_pre_two |=> !tx_in.valid || !tx_out_ready || tx_in_ready)
    else $error("prefix longer than two bytes");
  a_pre_valid: assert property (s_pre_hold |-> !tx_out.last)
    else $error("prefix byte marked last");
endmodule
bind bsdf_framer bsdf_framer_asserts u_chk (.pclk(pclk), .presetn(presetn),
  .ms_tick(ms_tick), .rx_in(rx_in), .rx_out(rx_out), .rx_abort(rx_abort), .tx_in(tx_in),
  .tx_in_ready(tx_in_ready), .tx_out(tx_out), .tx_out_ready(tx_out_ready));

// ---- bsdf_peer.sv ----
`timescale 1ns/1ps
// =====================================================
// Remote device: byte source and stalling sink
module bsdf_peer (
  // Control
  input wire logic             pclk,
  input wire logic             slow,
  // Streams
  output bsdf_pkg::bsdf_beat_t rx_in,
  input bsdf_pkg::bsdf_beat_t  tx_out,
  output logic                 tx_out_ready
);
  import bsdf_pkg::*;
  logic [7:0] got[$];
  logic [1:0] cnt_q = 2'h0;
  initial rx_in = '{valid: 1'b0, data: 8'h00, last: 1'b0};
  // Collect accepted bytes; stall one cycle in four when slow
  always @(posedge pclk) begin
    cnt_q <= cnt_q + 2'h1;
    if (tx_out.valid && tx_out_ready) got.push_back(tx_out.data);
  end
  assign tx_out_ready = !slow || cnt_q != 2'h3;
  // Idle line shows the inverse byte so stale data never looks fresh
  task send_byte(input logic [7:0] b);
    @(posedge pclk);
    rx_in <= '{valid: 1'b1, data: b, last: 1'b0};
    @(posedge pclk);
    rx_in <= '{valid: 1'b0, data: ~b, last: 1'b0};
  endtask
endmodule

// ---- tb_top.sv ----
`timescale 1ns/1ps
`include "bsdf_defs.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
// =====================================================
// Framer testbench
module tb_top;
  import bsdf_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, ms_tick, slow, er;
  logic        rx_abort, pready, pslverr, tx_in_ready, tx_out_ready;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  bsdf_beat_t  rx_in, rx_out, tx_in, tx_out;
  logic [8:0]  rxq[$];
  int          bad_count, compares, aborts;
  bsdf_framer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ms_tick(ms_tick), .rx_in(rx_in), .rx_out(rx_out),
    .rx_abort(rx_abort), .tx_in(tx_in), .tx_in_ready(tx_in_ready), .tx_out(tx_out),
    .tx_out_ready(tx_out_ready));
  bsdf_peer peer (.pclk(pclk), .slow(slow), .rx_in(rx_in), .tx_out(tx_out),
    .tx_out_ready(tx_out_ready));
  // Clock, watchdog and receive monitor
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  initial begin
    #200000;
    bad_count++;
    report_and_stop();
  end
  always @(posedge pclk) begin
    if (rx_out.valid) rxq.push_back({rx_out.last, rx_out.data});
    if (rx_abort) aborts++;
  end
  // =====================================================
  // Drivers; answers are taken at the rising edge that accepts them
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      bad_count++;
      report_and_stop();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task tx_byte(input logic [7:0] b, input logic l);
    int n;
    @(posedge pclk);
    tx_in <= '{valid: 1'b1, data: b, last: l};
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (!(tx_in_ready === 1'b1 && tx_out_ready === 1'b1) && n < 50);
    if (!(tx_in_ready === 1'b1 && tx_out_ready === 1'b1)) begin
      bad_count++;
      report_and_stop();
    end
    tx_in <= '{valid: 1'b0, data: ~b, last: 1'b0};
  endtask
  task ticks(input int k);
    repeat (k) begin
      repeat (5) @(posedge pclk);
      ms_tick <= 1'b1;
      @(posedge pclk);
      ms_tick <= 1'b0;
    end
  endtask
  task send_seq(input logic [7:0] s[$]);
    foreach (s[i]) peer.send_byte(s[i]);
  endtask
  task cmp_rx(input logic [8:0] e[$]);
    repeat (4) @(posedge pclk);
    `CHK(rxq.size(), e.size())
    foreach (e[i]) if (i < rxq.size()) `CHK(rxq[i], e[i])
    rxq.delete();
  endtask
  // =====================================================
  // Scenarios
  task t_regs();
    apb(1'b0, `BSDF_REG_TIMEOUT, 32'h0);
    `CHK(rd[15:0], `BSDF_TIMEOUT_RST)
    apb(1'b0, `BSDF_REG_CTRL, 32'h0);
    `CHK(rd[5:0], `BSDF_CTRL_RST)
    apb(1'b1, `BSDF_REG_RX_DELIM, 32'hff00_80ff);
    apb(1'b0, `BSDF_REG_RX_DELIM, 32'h0);
    `CHK(rd, 32'hff00_80ff)
    apb(1'b0, 12'h01c, 32'h0);
    `CHK({er, rd}, {1'b1, 32'h0})
    apb(1'b1, `BSDF_REG_TIMEOUT, 32'h2);
  endtask
  task t_rx();
    send_seq({8'h41, 8'h42});
    ticks(2);
    cmp_rx({9'h041, 9'h042, 9'h100});
    apb(1'b1, `BSDF_REG_RX_DELIM, 32'h000d_007e);
    apb(1'b1, `BSDF_REG_CTRL, 32'h5);
    send_seq({8'h11, 8'h7e, 8'h55, 8'h0d});
    cmp_rx({9'h055, 9'h10d});
    apb(1'b1, `BSDF_REG_RX_DELIM, 32'hddcc_bbaa);
    apb(1'b1, `BSDF_REG_CTRL, 32'ha);
    send_seq({8'haa, 8'h11, 8'haa, 8'hbb, 8'h22, 8'hcc, 8'hdd});
    cmp_rx({9'h022, 9'h0cc, 9'h1dd});
    send_seq({8'haa, 8'hbb, 8'h33});
    ticks(2);
    cmp_rx({9'h033});
    `CHK(aborts, 1)
  endtask
  // Every transmit prefix length, boundary delimiter values
  task t_tx();
    apb(1'b1, `BSDF_REG_TX_DELIM, 32'h0000_ff00);
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, `BSDF_REG_CTRL, 32'(k) << 4);
      peer.got.delete();
      tx_byte(8'h40, 1'b0);
      tx_byte(8'h41, 1'b1);
      repeat (4) @(posedge pclk);
      `CHK(peer.got.size(), k + 2)
      for (int i = 0; i < k; i++) `CHK(peer.got[i], i ? 8'hff : 8'h00)
      `CHK(peer.got[k], 8'h40)
    end
  endtask
  task report_and_stop();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Reset for two cycles, then the scenarios
  initial begin
    {presetn, psel, penable, pwrite, ms_tick, er} = 6'h00;
    {paddr, pwdata, rd, bad_count, compares, aborts} = '0;
    slow  = 1'b1;
    tx_in = '{valid: 1'b0, data: 8'h00, last: 1'b0};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_rx();
    t_tx();
    report_and_stop();
  end
endmodule
